// [inc/dcs_consts.svh]
// constants for the drive command and source selection block
// assumes the 40 MHz clk_in of the drive controller
//
// Function
// RULE1 - control mode: 0 volts-per-hertz, 1 vector
// RULE2 - pattern 0..17 fixed, 18 flexible
// RULE3 - rotation 0 forward, 1 reverse
// RULE4 - refuse reverse while reverse protection set
// RULE5 - main/alternate run source; active one starts/stops
// RULE6 - keypad stop stays emergency stop on terminals
// RULE7 - function 10 on: main run source, off: alternate
// RULE8 - main/alternate frequency source, codes 0..4
// RULE9 - function 14 on: main frequency source, off: alternate
// RULE10 - frequency priority: jog, preset, then source
// RULE11 - zero limit stops; else clamp to lower limit
// RULE12 - first ramp times 0.1 to 3600.0 s
// RULE13 - ramp time scaled by target over rated frequency
// RULE14 - function 07 off: ramp set 1, on: set 2
// RULE15 - functions 5/6 jog at jog frequency, ramps
// RULE16 - jog 1.00..25.00 Hz, jog ramps 0.1..25.5 s
// RULE17 - terminal modes: two-wire variants and three-wire
// RULE18 - forward and reverse together mean stop
// RULE19 - three-wire mode overrides first three assignments
// RULE20 - six terminals, each function code 0..21
// RULE21 - sample every 4 ms, accept N equal samples
// RULE22 - source selects use debounced inputs only
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

`define DCS_CLK_KHZ        40000
`define DCS_SCAN_MS        4
`define DCS_SCAN_CYCLES    (`DCS_SCAN_MS * `DCS_CLK_KHZ)
`define DCS_VF_MAX         5'h12
`define DCS_FUNC_MAX       5'h15
`define DCS_SRC_RUN_MAX    2'h2
`define DCS_SRC_FREQ_MAX   3'h4
`define DCS_EXT_MODE_MAX   2'h2
`define DCS_RAMP_MIN       16'h0001
`define DCS_RAMP_MAX       16'h8CA0
`define DCS_JOG_F_MIN      16'h0064
`define DCS_JOG_F_MAX      16'h09C4
`define DCS_JOG_T_MAX      16'h00FF
`define DCS_SCAN_N_MIN     8'h01
`define DCS_SCAN_N_MAX     8'hC8
`define DCS_FN_FWD         5'h00
`define DCS_FN_REV         5'h01
`define DCS_FN_PRESET0     5'h02
`define DCS_FN_PRESET1     5'h03
`define DCS_FN_PRESET2     5'h04
`define DCS_FN_JOG_FWD     5'h05
`define DCS_FN_JOG_REV     5'h06
`define DCS_FN_RAMP2       5'h07
`define DCS_FN_ESTOP       5'h08
`define DCS_FN_BASE_BLOCK  5'h09
`define DCS_FN_RUN_SEL     5'h0A
`define DCS_FN_FREQ_SEL    5'h0E
`define DCS_SRC_KEYPAD     2'h0
`define DCS_SRC_TERMINAL   2'h1
`define DCS_SRC_COMM       2'h2
`define DCS_MODE_FR        2'h0
`define DCS_MODE_RUN_DIR   2'h1
`define DCS_MODE_3WIRE     2'h2
`define DCS_RST_SCAN_N     8'h01

`endif

// [inc/dcs_pkg.sv]
// types of the drive command and source selection block
// assumes dcs_consts.svh supplies the numeric constants
package dcs_pkg;
	typedef logic [4:0]  dcs_code_t;
	typedef logic [15:0] dcs_val_t;

	// one validated parameter set
	typedef struct packed {
		logic                  ctrl_mode;
		logic [4:0]            vf_pattern;
		logic                  rotation;
		logic                  rev_protect;
		logic [1:0]            run_src_main;
		logic [1:0]            run_src_alt;
		logic [2:0]            freq_src_main;
		logic [2:0]            freq_src_alt;
		logic [1:0]            ext_mode;
		dcs_val_t              acc1;
		dcs_val_t              dec1;
		dcs_val_t              acc2;
		dcs_val_t              dec2;
		dcs_val_t              jog_freq;
		dcs_val_t              jog_acc;
		dcs_val_t              jog_dec;
		dcs_val_t              lower_limit;
		logic [7:0]            scan_n;
		dcs_code_t [5:0]       mfi_func;
	} dcs_cfg_s;

	// frequency references, 0.01 Hz units
	typedef struct packed {
		dcs_val_t keypad_updown;
		dcs_val_t keypad_pot;
		dcs_val_t analog;
		dcs_val_t ext_updown;
		dcs_val_t comm;
		dcs_val_t preset;
		dcs_val_t rated;
	} dcs_freq_s;

	typedef enum logic [1:0] {
		DCS_IDLE,
		DCS_ACTIVE,
		DCS_ESTOP
	} dcs_run_e;
endpackage : dcs_pkg

// [logic/dcs_select.sv]
// run source, frequency source, ramp set and terminal function selection
// assumes keypad and comm inputs are on clk_in, terminals are raw pins
`timescale 1ns/10ps
`include "dcs_consts.svh"

module dcs_select
	import dcs_pkg::*;
#(
	parameter int SCAN_CYCLES = `DCS_SCAN_CYCLES
) (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire dcs_cfg_s    cfg_in,
	input  wire logic        cfg_load_in,
	input  wire logic [5:0]  terminal_in,
	input  wire logic        keypad_run_in,
	input  wire logic        keypad_stop_in,
	input  wire logic        keypad_rev_in,
	input  wire logic        comm_run_in,
	input  wire logic        comm_rev_in,
	input  wire dcs_freq_s   freq_in,
	output logic             cfg_reject_out,
	output dcs_cfg_s         cfg_out,
	output logic             vector_mode_out,
	output logic             vf_flex_out,
	output logic [5:0]       term_level_out,
	output logic [1:0]       run_src_out,
	output logic [2:0]       freq_src_out,
	output logic             run_out,
	output logic             reverse_out,
	output logic             estop_out,
	output logic             zero_speed_out,
	output logic             jog_out,
	output logic [2:0]       preset_idx_out,
	output logic [15:0]      freq_out,
	output logic [1:0]       ramp_set_out,
	output logic [31:0]      acc_time_out,
	output logic [31:0]      dec_time_out
);
	// ramp duration = setting * target / rated
	function automatic logic [31:0] ramp_scale(input dcs_val_t t, input dcs_val_t f,
		input dcs_val_t r);
		logic [31:0] prod;
		prod = {16'h0000, t} * {16'h0000, f};
		if (r == 16'h0000) begin
			ramp_scale = {16'h0000, t};
		end else begin
			ramp_scale = prod / {16'h0000, r};
		end
	endfunction : ramp_scale

	// frequency source code to reference
	function automatic dcs_val_t src_freq(input logic [2:0] s, input dcs_freq_s f);
		case (s)
			3'h0:    src_freq = f.keypad_updown;
			3'h1:    src_freq = f.keypad_pot;
			3'h2:    src_freq = f.analog;
			3'h3:    src_freq = f.ext_updown;
			default: src_freq = f.comm;
		endcase
	endfunction : src_freq

	dcs_cfg_s        cfg;
	logic [5:0]      sync1;
	logic [5:0]      sync2;
	logic [5:0]      sync3;
	logic [5:0]      deb;
	logic [7:0]      cnt [6];
	logic [17:0]     tick_cnt;
	logic            kp_latch;
	logic            tw_latch;
	dcs_run_e        state;
	dcs_run_e        next_state;

	// parameter set validation
	wire cfg_ok_vf   = cfg_in.vf_pattern <= `DCS_VF_MAX;                  // RULE2
	wire cfg_ok_rot  = !(cfg_in.rotation && cfg_in.rev_protect);         // RULE4
	wire cfg_ok_src  = cfg_in.run_src_main <= `DCS_SRC_RUN_MAX
		&& cfg_in.run_src_alt <= `DCS_SRC_RUN_MAX
		&& cfg_in.freq_src_main <= `DCS_SRC_FREQ_MAX
		&& cfg_in.freq_src_alt <= `DCS_SRC_FREQ_MAX;                     // RULE5 RULE8
	wire cfg_ok_mode = cfg_in.ext_mode <= `DCS_EXT_MODE_MAX;             // RULE17
	wire cfg_ok_ramp = cfg_in.acc1 >= `DCS_RAMP_MIN && cfg_in.acc1 <= `DCS_RAMP_MAX
		&& cfg_in.dec1 >= `DCS_RAMP_MIN && cfg_in.dec1 <= `DCS_RAMP_MAX; // RULE12
	wire cfg_ok_jog  = cfg_in.jog_freq >= `DCS_JOG_F_MIN
		&& cfg_in.jog_freq <= `DCS_JOG_F_MAX
		&& cfg_in.jog_acc >= `DCS_RAMP_MIN && cfg_in.jog_acc <= `DCS_JOG_T_MAX
		&& cfg_in.jog_dec >= `DCS_RAMP_MIN && cfg_in.jog_dec <= `DCS_JOG_T_MAX; // RULE16
	wire cfg_ok_scan = cfg_in.scan_n >= `DCS_SCAN_N_MIN && cfg_in.scan_n <= `DCS_SCAN_N_MAX;
	logic cfg_ok_fn;
	always_comb begin
		cfg_ok_fn = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (cfg_in.mfi_func[i] > `DCS_FUNC_MAX) begin
				cfg_ok_fn = 1'b0;                                    // RULE20
			end
		end
	end
	wire cfg_ok = cfg_ok_vf && cfg_ok_rot && cfg_ok_src && cfg_ok_mode && cfg_ok_ramp
		&& cfg_ok_jog && cfg_ok_scan && cfg_ok_fn;

	// load only a fully valid set, else keep the old one
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg <= '0;
			cfg.scan_n <= `DCS_RST_SCAN_N;
			cfg_reject_out <= 1'b0;
		end else begin
			cfg_reject_out <= cfg_load_in && !cfg_ok;                // RULE4
			if (cfg_load_in && cfg_ok) begin
				cfg <= cfg_in;
			end
		end
	end

	// three-flop synchroniser on the terminal pins
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			sync3 <= 6'h00;
		end else begin
			sync1 <= terminal_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// scan tick every 4 ms
	wire scan_tick = tick_cnt == 18'(SCAN_CYCLES - 1);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_cnt <= 18'h0_0000;
		end else begin
			tick_cnt <= scan_tick ? 18'h0_0000 : tick_cnt + 18'h0_0001;   // RULE21
		end
	end

	// per terminal: a level is taken after N equal scans, shorter runs dropped
	// one process owns all levels and counters, so each has a single driver
	wire [5:0] stable = sync2 ~^ sync3;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			deb <= 6'h00;
			for (int i = 0; i < 6; i++) begin
				cnt[i] <= 8'h00;
			end
		end else if (scan_tick) begin
			for (int i = 0; i < 6; i++) begin
				if (stable[i]) begin
					if (sync3[i] == deb[i]) begin
						cnt[i] <= 8'h00;                             // RULE21
					end else if (cnt[i] + 8'h01 >= cfg.scan_n) begin
						deb[i] <= sync3[i];                          // RULE21 RULE22
						cnt[i] <= 8'h00;
					end else begin
						cnt[i] <= cnt[i] + 8'h01;
					end
				end
			end
		end
	end

	// function decode on debounced levels; three-wire owns the first three
	logic [21:0] fn_on;
	logic [21:0] fn_used;
	always_comb begin
		fn_on = 22'h0;
		fn_used = 22'h0;
		for (int i = 0; i < 6; i++) begin
			if (!(cfg.ext_mode == `DCS_MODE_3WIRE && i < 3)) begin        // RULE19
				if (cfg.mfi_func[i] <= `DCS_FUNC_MAX) begin
					fn_used[cfg.mfi_func[i]] = 1'b1;                 // RULE20
					fn_on[cfg.mfi_func[i]] = fn_on[cfg.mfi_func[i]] | deb[i];
				end
			end
		end
	end

	// source selection by functions 10 and 14
	wire [1:0] run_src = (fn_used[`DCS_FN_RUN_SEL] && !fn_on[`DCS_FN_RUN_SEL])
		? cfg.run_src_alt : cfg.run_src_main;                          // RULE7 RULE22
	wire [2:0] freq_src = (fn_used[`DCS_FN_FREQ_SEL] && !fn_on[`DCS_FN_FREQ_SEL])
		? cfg.freq_src_alt : cfg.freq_src_main;                        // RULE9 RULE22
	wire on_terms = run_src == `DCS_SRC_TERMINAL;

	// terminal run command by operation mode
	wire fr_fwd  = fn_on[`DCS_FN_FWD];
	wire fr_rev  = fn_on[`DCS_FN_REV];
	wire both_fr = fr_fwd && fr_rev;                                   // RULE18
	logic ext_run;
	logic ext_rev;
	always_comb begin
		case (cfg.ext_mode)
			`DCS_MODE_FR: begin
				ext_run = (fr_fwd || fr_rev) && !both_fr;                // RULE17 RULE18
				ext_rev = fr_rev;
			end
			`DCS_MODE_RUN_DIR: begin
				ext_run = deb[0];                                        // RULE17
				ext_rev = deb[1];
			end
			default: begin
				ext_run = tw_latch;                                      // RULE17 RULE19
				ext_rev = deb[2];
			end
		endcase
	end

	// three-wire: run closes latch, opened stop contact releases it
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tw_latch <= 1'b0;
		end else if (cfg.ext_mode != `DCS_MODE_3WIRE || !deb[1]) begin
			tw_latch <= 1'b0;                                            // RULE19
		end else if (deb[0]) begin
			tw_latch <= 1'b1;
		end
	end

	// keypad run latch
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			kp_latch <= 1'b0;
		end else if (keypad_stop_in) begin
			kp_latch <= 1'b0;
		end else if (keypad_run_in && run_src == `DCS_SRC_KEYPAD) begin
			kp_latch <= 1'b1;
		end
	end

	// active source drives run and direction; jog functions 5/6 also run and set direction from any source
	logic cmd_run;
	logic cmd_rev;
	always_comb begin
		case (run_src)
			`DCS_SRC_KEYPAD: begin
				cmd_run = kp_latch;                                      // RULE5
				cmd_rev = keypad_rev_in;
			end
			`DCS_SRC_TERMINAL: begin
				cmd_run = ext_run;                                       // RULE5
				cmd_rev = ext_rev;
			end
			default: begin
				cmd_run = comm_run_in;                                   // RULE5
				cmd_rev = comm_rev_in;
			end
		endcase
	end

	// jog and stop causes
	wire jog_f   = fn_on[`DCS_FN_JOG_FWD];
	wire jog_r   = fn_on[`DCS_FN_JOG_REV];
	wire jog     = jog_f ^ jog_r;                                      // RULE15 RULE18
	wire want    = cmd_run || jog;
	wire kill    = fn_on[`DCS_FN_ESTOP] || fn_on[`DCS_FN_BASE_BLOCK]
		|| (on_terms && keypad_stop_in);                               // RULE6

	// run state: emergency stop holds until the command and every stop cause are removed
	always_comb begin
		case (state)
			DCS_IDLE:   next_state = (want && !kill) ? DCS_ACTIVE : DCS_IDLE;
			DCS_ACTIVE: next_state = kill ? DCS_ESTOP : (want ? DCS_ACTIVE : DCS_IDLE);
			DCS_ESTOP:  next_state = (want || kill) ? DCS_ESTOP : DCS_IDLE; // RULE6
			default:    next_state = DCS_IDLE;
		endcase
	end

	// frequency priority and lower limit
	wire [2:0] preset_idx = {fn_on[`DCS_FN_PRESET2], fn_on[`DCS_FN_PRESET1],
		fn_on[`DCS_FN_PRESET0]};
	wire dcs_val_t sel_freq = jog ? cfg.jog_freq
		: (preset_idx != 3'h0) ? freq_in.preset
		: src_freq(freq_src, freq_in);                                 // RULE10 RULE8
	wire zero_stop = sel_freq == 16'h0000 && cfg.lower_limit == 16'h0000; // RULE11
	wire dcs_val_t lim_freq = (sel_freq <= cfg.lower_limit) ? cfg.lower_limit
		: sel_freq;                                                    // RULE11

	// ramp set: jog, then set 2 by function 07, else set 1
	wire [1:0] ramp_set = jog ? 2'h2 : (fn_on[`DCS_FN_RAMP2] ? 2'h1 : 2'h0); // RULE14 RULE15
	wire dcs_val_t acc_sel = jog ? cfg.jog_acc : (ramp_set == 2'h1 ? cfg.acc2 : cfg.acc1);
	wire dcs_val_t dec_sel = jog ? cfg.jog_dec : (ramp_set == 2'h1 ? cfg.dec2 : cfg.dec1);
	wire dir_rev = (jog ? jog_r : cmd_rev) ^ cfg.rotation;             // RULE3

	// registered outputs
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= DCS_IDLE;
			run_out <= 1'b0;
			reverse_out <= 1'b0;
			estop_out <= 1'b0;
			zero_speed_out <= 1'b0;
			jog_out <= 1'b0;
			preset_idx_out <= 3'h0;
			freq_out <= 16'h0000;
			ramp_set_out <= 2'h0;
			acc_time_out <= 32'h0000_0000;
			dec_time_out <= 32'h0000_0000;
			run_src_out <= 2'h0;
			freq_src_out <= 3'h0;
			term_level_out <= 6'h00;
			vector_mode_out <= 1'b0;
			vf_flex_out <= 1'b0;
			cfg_out <= '0;
		end else begin
			state <= next_state;
			run_out <= next_state == DCS_ACTIVE;                         // RULE5
			reverse_out <= dir_rev;
			estop_out <= next_state == DCS_ESTOP;
			zero_speed_out <= zero_stop;
			jog_out <= jog;
			preset_idx_out <= preset_idx;
			freq_out <= zero_stop ? 16'h0000 : lim_freq;                 // RULE11
			ramp_set_out <= ramp_set;
			acc_time_out <= ramp_scale(acc_sel, lim_freq, freq_in.rated); // RULE13
			dec_time_out <= ramp_scale(dec_sel, lim_freq, freq_in.rated); // RULE13
			run_src_out <= run_src;
			freq_src_out <= freq_src;
			term_level_out <= deb;
			vector_mode_out <= cfg.ctrl_mode;                            // RULE1
			vf_flex_out <= cfg.vf_pattern == `DCS_VF_MAX;                // RULE2
			cfg_out <= cfg;
		end
	end

	// checks
	rev_refuse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		cfg_load_in && cfg_in.rotation && cfg_in.rev_protect |=> cfg_reject_out
		&& cfg == $past(cfg)) else $error("reverse not refused"); // RULE4
	both_stop_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		on_terms && cfg.ext_mode == `DCS_MODE_FR && both_fr && !jog |=> !run_out)
		else $error("fwd and rev together ran"); // RULE18
	jog_freq_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		jog && cfg.jog_freq > cfg.lower_limit |=> freq_out == $past(cfg.jog_freq)
		&& ramp_set_out == 2'h2) else $error("jog not prioritised"); // RULE10
	lower_lim_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		cfg.lower_limit != 16'h0000 |=> freq_out >= $past(cfg.lower_limit))
		else $error("below lower limit"); // RULE11
	ramp_two_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!jog && fn_on[`DCS_FN_RAMP2] |=> ramp_set_out == 2'h1)
		else $error("ramp set 2 not chosen"); // RULE14
	run_sel_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		fn_used[`DCS_FN_RUN_SEL] && !fn_on[`DCS_FN_RUN_SEL]
		|=> run_src_out == $past(cfg.run_src_alt)) else $error("run source wrong"); // RULE7
	freq_sel_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		fn_used[`DCS_FN_FREQ_SEL] && fn_on[`DCS_FN_FREQ_SEL]
		|=> freq_src_out == $past(cfg.freq_src_main)) else $error("freq source wrong"); // RULE9
	deb_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!scan_tick |=> deb == $past(deb)) else $error("level taken off tick"); // RULE21
	estop_key_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		run_out && on_terms && keypad_stop_in |=> !run_out ##1 !run_out)
		else $error("keypad stop ignored"); // RULE6
endmodule : dcs_select

// [testbench/dcs_partner.sv]
// keypad and terminal switches standing in front of the selector
// assumes the bench changes wanted levels by non-blocking writes at falling edges
`timescale 1ns/10ps

module dcs_partner (
	input  wire logic       clk_in,
	input  wire logic [5:0] want_term_in,
	input  wire logic       press_run_in,
	input  wire logic       press_stop_in,
	output logic [5:0]      terminal_out,
	output logic            keypad_run_out,
	output logic            keypad_stop_out
);
	logic [5:0] last;
	logic [5:0] flip;
	logic [1:0] chat;
	logic       run_d;
	logic       stop_d;

	// quiet switches and released keys at power-up
	initial begin
		{last, flip, chat, run_d, stop_d} = '0;
		{terminal_out, keypad_run_out, keypad_stop_out} = '0;
	end

	// contacts bounce back once shortly after each change
	always @(negedge clk_in) begin
		if (want_term_in != last) begin
			chat <= 2'h3;
			flip <= want_term_in ^ last;
		end else if (chat != 2'h0) begin
			chat <= chat - 2'h1;
		end
		last         <= want_term_in;
		terminal_out <= want_term_in ^ ((chat == 2'h2) ? flip : 6'h00);
	end

	// a key press gives one pulse of a single cycle
	always @(negedge clk_in) begin
		run_d           <= press_run_in;
		stop_d          <= press_stop_in;
		keypad_run_out  <= press_run_in & ~run_d;
		keypad_stop_out <= press_stop_in & ~stop_d;
	end
endmodule : dcs_partner

// [testbench/dcs_select_bench.sv]
// self-checking bench of the command and source selector
// assumes a 40 MHz clock and a terminal scan shortened to 4 cycles
`timescale 1ns/10ps

module dcs_select_bench;
	import dcs_pkg::*;
	typedef struct {int sel; logic [31:0] exp;} dcs_note_s;
	logic clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic cfg_load_in = 1'h0;
	logic keypad_rev_in = 1'h0;
	logic comm_run_in = 1'h0;
	logic comm_rev_in = 1'h0;
	logic press_run = 1'h0;
	logic press_stop = 1'h0;
	logic [5:0] want = 6'h00;
	dcs_cfg_s cfg_in = '0;
	dcs_freq_s freq_in = '0;
	dcs_cfg_s good;
	dcs_cfg_s bad;
	logic [5:0] terminal_in;
	logic keypad_run_in, keypad_stop_in;
	logic cfg_reject_out, vector_mode_out, vf_flex_out, run_out, reverse_out;
	logic estop_out, zero_speed_out, jog_out;
	dcs_cfg_s cfg_out;
	logic [5:0] term_level_out;
	logic [1:0] run_src_out, ramp_set_out;
	logic [2:0] freq_src_out, preset_idx_out;
	logic [15:0] freq_out;
	logic [31:0] acc_time_out, dec_time_out;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	int k, k2, kj, r;
	dcs_note_s notes[$];
	event chk_ev;
	string nm[17] = '{"reject", "vector", "vf_flex", "term", "run_src", "freq_src",
		"run", "reverse", "estop", "zero_speed", "jog", "freq", "ramp_set", "acc", "dec",
		"cfg_acc1", "preset_idx"};

	always #12.5 clk_in = ~clk_in;

	dcs_select #(.SCAN_CYCLES(4)) i_dcs_select (.clk_in(clk_in), .nrst_in(nrst_in),
		.cfg_in(cfg_in), .cfg_load_in(cfg_load_in), .terminal_in(terminal_in),
		.keypad_run_in(keypad_run_in), .keypad_stop_in(keypad_stop_in),
		.keypad_rev_in(keypad_rev_in), .comm_run_in(comm_run_in),
		.comm_rev_in(comm_rev_in), .freq_in(freq_in), .cfg_reject_out(cfg_reject_out),
		.cfg_out(cfg_out), .vector_mode_out(vector_mode_out), .vf_flex_out(vf_flex_out),
		.term_level_out(term_level_out), .run_src_out(run_src_out),
		.freq_src_out(freq_src_out), .run_out(run_out), .reverse_out(reverse_out),
		.estop_out(estop_out), .zero_speed_out(zero_speed_out), .jog_out(jog_out),
		.preset_idx_out(preset_idx_out), .freq_out(freq_out),
		.ramp_set_out(ramp_set_out), .acc_time_out(acc_time_out),
		.dec_time_out(dec_time_out));

	dcs_partner i_dcs_partner (.clk_in(clk_in), .want_term_in(want),
		.press_run_in(press_run), .press_stop_in(press_stop),
		.terminal_out(terminal_in), .keypad_run_out(keypad_run_in),
		.keypad_stop_out(keypad_stop_in));

	// output chosen by a note
	function automatic logic [31:0] pick(input int s);
		case (s)
			0: pick = 32'(cfg_reject_out);
			1: pick = 32'(vector_mode_out);
			2: pick = 32'(vf_flex_out);
			3: pick = 32'(term_level_out);
			4: pick = 32'(run_src_out);
			5: pick = 32'(freq_src_out);
			6: pick = 32'(run_out);
			7: pick = 32'(reverse_out);
			8: pick = 32'(estop_out);
			9: pick = 32'(zero_speed_out);
			10: pick = 32'(jog_out);
			11: pick = 32'(freq_out);
			12: pick = 32'(ramp_set_out);
			13: pick = acc_time_out;
			14: pick = dec_time_out;
			15: pick = 32'(cfg_out.acc1);
			default: pick = 32'(preset_idx_out);
		endcase
	endfunction : pick

	task automatic cmp_flag(input string n, input logic e, input logic a);
		n_compared++;
		if (a !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", n, e, a);
		end
	endtask : cmp_flag

	task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] a);
		n_compared++;
		if (a !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, a);
		end
	endtask : cmp_word

	// takes the oldest notes off the queue when results are ready
	always begin : watch
		dcs_note_s n;
		logic [31:0] a;
		@(chk_ev);
		while (notes.size() > 0) begin
			n = notes.pop_front();
			a = pick(n.sel);
			if (n.sel inside {0, 1, 2, 6, 7, 8, 9, 10}) cmp_flag(nm[n.sel], n.exp[0], a[0]);
			else cmp_word(nm[n.sel], n.exp, a);
		end
	end

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic note(input int s, input logic [31:0] e);
		notes.push_back('{s, e});
	endtask : note

	task automatic look();
		-> chk_ev;
		cyc(1);
	endtask : look

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc

	// load a set; the refusal pulse stands in the cycle after
	task automatic load(input dcs_cfg_s c);
		cfg_in <= c;
		cfg_load_in <= 1'h1;
		cyc(1);
		cfg_load_in <= 1'h0;
	endtask : load

	task automatic terms(input logic [5:0] v);
		want <= v;
		for (int i = 0; i < 60 && term_level_out !== v; i++) cyc(1);
		cyc(2);
	endtask : terms

	task automatic press(input logic stop);
		if (stop) press_stop <= 1'h1;
		else press_run <= 1'h1;
		cyc(2);
		{press_run, press_stop} <= 2'h0;
		cyc(3);
	endtask : press

	// hang guard
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		r = $urandom(16344);
		k = $urandom_range(5, 1);
		k2 = $urandom_range(5, 1);
		kj = $urandom_range(5, 1);
		good = '0;
		good.ctrl_mode = 1'h1;
		good.vf_pattern = 5'h12;
		good.run_src_main = 2'h1;
		good.freq_src_main = 3'h2;
		good.freq_src_alt = 3'h4;
		good.acc1 = 16'(10 * $urandom_range(3600, 1));
		good.dec1 = 16'h0064;
		good.acc2 = 16'(10 * $urandom_range(3600, 1));
		good.dec2 = 16'h00C8;
		good.jog_freq = 16'(500 * kj);
		good.jog_acc = 16'(10 * $urandom_range(25, 1));
		good.jog_dec = 16'h0032;
		good.scan_n = 8'h02;
		good.mfi_func = {5'h07, 5'h05, 5'h0E, 5'h0A, 5'h01, 5'h00};
		freq_in.comm <= 16'(500 * k);
		freq_in.analog <= 16'(500 * k2);
		freq_in.rated <= 16'h1388;
		cyc(20);
		nrst_in <= 1'h1;
		cyc(2);
		note(6, 0); note(4, 0); note(3, 0); note(1, 0); look();
		note(2, 0); note(15, 0); look();
		// every kind of bad field is refused and the old set kept
		for (int i = 0; i < 11; i++) begin
			bad = good;
			case (i)
				0: bad.vf_pattern = 5'h13;
				1: {bad.rotation, bad.rev_protect} = 2'h3;
				2: bad.run_src_main = 2'h3;
				3: bad.freq_src_alt = 3'h5;
				4: bad.acc1 = 16'h0000;
				5: bad.acc1 = 16'h8CA1;
				6: bad.jog_freq = 16'h09C5;
				7: bad.jog_acc = 16'h0000;
				8: bad.ext_mode = 2'h3;
				9: bad.mfi_func[2] = 5'h16;
				default: bad.scan_n = 8'h00;
			endcase
			load(bad);
			note(0, 1); look();
			cyc(2);
			note(1, 0); look();
		end
		load(good);
		note(0, 0); look();
		cyc(2);
		note(1, 1); note(2, 1); note(4, 0); note(5, 4); look();
		note(15, good.acc1); look();
		keypad_rev_in <= 1'h1;
		press(1'h0);
		note(6, 1); note(11, 500 * k); note(12, 0); look();
		note(7, 1); look();
		note(13, good.acc1 * k / 10); note(14, 10 * k); look();
		press(1'h1);
		terms(6'h01);
		note(6, 0); look();
		terms(6'h05);
		note(4, 1); note(6, 1); note(7, 0); look();
		// a short pulse on the frequency select is noise
		want <= 6'h0D;
		cyc(1);
		want <= 6'h05;
		cyc(30);
		note(3, 6'h05); note(5, 4); look();
		terms(6'h0D);
		note(5, 2); note(11, 500 * k2); look();
		terms(6'h0F);
		note(6, 0); look();
		terms(6'h0E);
		note(6, 1); note(7, 1); look();
		terms(6'h2E);
		note(12, 1); note(13, good.acc2 * k2 / 10); note(14, 20 * k2); look();
		press(1'h1);
		note(8, 1); note(6, 0); look();
		terms(6'h2C);
		note(8, 0); look();
		terms(6'h1C);
		note(10, 1); note(11, good.jog_freq); note(12, 2); look();
		note(13, good.jog_acc * kj / 10); note(14, 5 * kj); look();
		terms(6'h05);
		good.lower_limit = 16'h0BB8;
		load(good);
		cyc(4);
		note(11, 16'h0BB8); note(9, 0); look();
		good.lower_limit = 16'h0000;
		freq_in.comm <= 16'h0000;
		load(good);
		cyc(4);
		note(11, 0); note(9, 1); look();
		// preset outranks the source reference
		good.mfi_func[5] = 5'h02;
		freq_in.preset <= 16'(500 * k);
		load(good);
		terms(6'h25);
		note(16, 1); note(11, 500 * k); look();
		// run/stop plus direction terminals
		good.ext_mode = 2'h1;
		load(good);
		terms(6'h07);
		note(6, 1); note(7, 1); look();
		// three-wire: terminal three loses its source-select function
		good.ext_mode = 2'h2;
		load(good);
		cyc(4);
		note(4, 1); note(6, 1); note(7, 1); look();
		terms(6'h02);
		note(6, 1); note(7, 0); look();
		terms(6'h00);
		note(6, 0); look();
		// alternate source on communication
		good.ext_mode = 2'h0;
		good.run_src_alt = 2'h2;
		load(good);
		comm_run_in <= 1'h1;
		comm_rev_in <= 1'h1;
		cyc(3);
		note(4, 2); note(6, 1); note(7, 1); look();
		give_verdict();
	end
endmodule : dcs_select_bench
